// *** inc/phy_ctl_pkg.sv ***
// Purpose: constants for the transceiver special control bits 7:2
// Assumes: one 16-bit register behind a plain strobe port
// Notes: offset chosen locally, bits outside 7:2 read zero
package phy_ctl_pkg;
  localparam logic [4:0] ctl_offset = 5'h10;
  localparam int self_test_bit = 2;
  localparam int mac_pwr_bit = 3;
  localparam int clk_dis_bit = 4;
  localparam int xover_lo = 5;
  localparam int xover_hi = 6;
  localparam int threshold_bit = 7;
  localparam logic rst_self_test = 1'h0;
  localparam logic rst_mac_pwr = 1'h1;
  localparam logic rst_clk_dis = 1'h0;
  localparam logic [1:0] rst_xover = 2'h3;
  localparam logic rst_threshold = 1'h0;
  typedef enum logic [1:0] {
    xover_mdi = 2'b00,
    xover_mdix = 2'b01,
    xover_resv = 2'b10,
    xover_auto = 2'b11
  } xover_mode_t;
endpackage

// *** hw/phy_special_control.sv ***
// Purpose: special control register bits 7:2 and their decoded controls
// Assumes: inputs synchronous to clk_i
// Notes: analog effects of each control live outside this block
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
module phy_special_control #(
  parameter bit alt_variant = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic soft_rst_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic ref_clk_i,
  output logic gigabit_ref_clock_out_o,
  output logic collision_self_test_o,
  output logic mac_always_powered_o,
  output logic force_mdi_o,
  output logic force_mdix_o,
  output logic auto_crossover_o,
  output logic low_threshold_o
);
  logic self_test, next_self_test;
  logic mac_pwr, next_mac_pwr;
  logic clk_dis, next_clk_dis;
  logic [1:0] xover, next_xover;
  logic threshold, next_threshold;
  logic [15:0] next_rdata;
  logic hit;
  logic dis_eff;
  logic auto_eff;

  // one place for the crossover code compare, used by the auto, mdi and mdix outputs
  function automatic logic xover_is(input logic [1:0] x, input phy_ctl_pkg::xover_mode_t m);
    return x == m;
  endfunction

  assign hit = addr_i == phy_ctl_pkg::ctl_offset;

  always_comb begin
    next_self_test = self_test;
    next_mac_pwr = mac_pwr;
    next_clk_dis = clk_dis;
    next_xover = xover;
    next_threshold = threshold;
    if (soft_rst_i) begin
      // write in the same cycle loses to the reload
      next_mac_pwr = phy_ctl_pkg::rst_mac_pwr;
      next_clk_dis = phy_ctl_pkg::rst_clk_dis;
      next_xover = phy_ctl_pkg::rst_xover;
    end else if (wr_i && hit) begin
      next_self_test = wdata_i[phy_ctl_pkg::self_test_bit];
      next_mac_pwr = wdata_i[phy_ctl_pkg::mac_pwr_bit];
      next_clk_dis = wdata_i[phy_ctl_pkg::clk_dis_bit];
      next_xover = wdata_i[phy_ctl_pkg::xover_hi:phy_ctl_pkg::xover_lo];
      next_threshold = wdata_i[phy_ctl_pkg::threshold_bit];
    end
    next_rdata = 16'h0000;
    if (rd_i && hit) begin
      next_rdata[phy_ctl_pkg::self_test_bit] = self_test;
      next_rdata[phy_ctl_pkg::mac_pwr_bit] = mac_pwr;
      next_rdata[phy_ctl_pkg::clk_dis_bit] = clk_dis;
      next_rdata[phy_ctl_pkg::xover_hi:phy_ctl_pkg::xover_lo] = xover;
      next_rdata[phy_ctl_pkg::threshold_bit] = threshold;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      self_test <= phy_ctl_pkg::rst_self_test;
      mac_pwr <= phy_ctl_pkg::rst_mac_pwr;
      clk_dis <= phy_ctl_pkg::rst_clk_dis;
      xover <= phy_ctl_pkg::rst_xover;
      threshold <= phy_ctl_pkg::rst_threshold;
      rdata_o <= 16'h0000;
    end else begin
      self_test <= next_self_test;
      mac_pwr <= next_mac_pwr;
      clk_dis <= next_clk_dis;
      xover <= next_xover;
      threshold <= next_threshold;
      rdata_o <= next_rdata;
    end
  end

  // on the alternate variant bit 4 is ignored; software keeps it zero elsewhere too
  assign dis_eff = alt_variant ? xover[1] : clk_dis;
  assign auto_eff = alt_variant ? xover[0] : xover_is(xover, phy_ctl_pkg::xover_auto);
  // gating is combinational; a glitch-free gate would cost a latch cell
  assign gigabit_ref_clock_out_o = ref_clk_i & ~dis_eff;
  assign collision_self_test_o = self_test;
  assign mac_always_powered_o = mac_pwr;
  assign force_mdi_o = !alt_variant && xover_is(xover, phy_ctl_pkg::xover_mdi);
  assign force_mdix_o = !alt_variant && xover_is(xover, phy_ctl_pkg::xover_mdix);
  assign auto_crossover_o = auto_eff;
  assign low_threshold_o = threshold;

  a_hw_reset_values: assert property (@(posedge clk_i)
    $past(sys_rst_i)
    |-> !self_test && mac_pwr && !clk_dis && xover == 2'h3 && !threshold)
    else $error("wrong value after hardware reset");

  a_soft_keep_fields: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    soft_rst_i
    |=> self_test == $past(self_test) && threshold == $past(threshold))
    else $error("soft reset changed kept fields");

  a_soft_reload_fields: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    soft_rst_i
    |=> mac_pwr && !clk_dis && xover == 2'h3)
    else $error("soft reset did not reload fields");

  a_write_self_test: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_i && hit && !soft_rst_i
    |=> self_test == $past(wdata_i[2]))
    else $error("self test bit not written");

  a_write_threshold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_i && hit && !soft_rst_i
    |=> low_threshold_o == $past(wdata_i[7]))
    else $error("threshold bit not written");

  a_write_mac_pwr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_i && hit && !soft_rst_i
    |=> mac_always_powered_o == $past(wdata_i[3]))
    else $error("power bit not written");

  a_write_clk_dis: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_i && hit && !soft_rst_i
    |=> clk_dis == $past(wdata_i[4]))
    else $error("clock disable bit not written");

  a_write_xover: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_i && hit && !soft_rst_i
    |=> xover == $past(wdata_i[6:5]))
    else $error("crossover field not written");

  a_fields_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(wr_i && hit) && !soft_rst_i
    |=> $stable(self_test) && $stable(mac_pwr) && $stable(xover) && $stable(threshold))
    else $error("field changed without a write");

  a_clock_held_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    dis_eff
    |-> !gigabit_ref_clock_out_o)
    else $error("reference clock not held low");

  a_clock_passes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !dis_eff
    |-> gigabit_ref_clock_out_o == ref_clk_i)
    else $error("reference clock not passed");

  a_xover_decode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !alt_variant
    |-> auto_crossover_o == (xover == 2'h3) && force_mdi_o == (xover == 2'h0)
      && force_mdix_o == (xover == 2'h1))
    else $error("crossover decode wrong");

  a_reserved_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !alt_variant && xover == 2'h2
    |-> !force_mdi_o && !force_mdix_o && !auto_crossover_o)
    else $error("reserved crossover code acted");

  a_alt_mapping: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alt_variant
    |-> auto_crossover_o == xover[0] && dis_eff == xover[1])
    else $error("alternate bit mapping wrong");

  a_alt_no_force: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alt_variant
    |-> !force_mdi_o && !force_mdix_o)
    else $error("alternate variant forced a crossover");

  a_read_data: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_i && hit
    |=> rdata_o[7:2] == {$past(threshold), $past(xover), $past(clk_dis),
      $past(mac_pwr), $past(self_test)} && rdata_o[15:8] == 8'h00 && rdata_o[1:0] == 2'h0)
    else $error("read data wrong");

  a_read_idle_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(rd_i && hit)
    |=> rdata_o == 16'h0000)
    else $error("read data not cleared");

  c_soft_reset: cover property (@(posedge clk_i) soft_rst_i && self_test);
  c_manual_mdix: cover property (@(posedge clk_i) force_mdix_o);
  c_clock_disabled: cover property (@(posedge clk_i) dis_eff);
  c_read_back: cover property (@(posedge clk_i) rd_i && hit ##1 rdata_o[7]);
  c_alt_auto: cover property (@(posedge clk_i) alt_variant && auto_crossover_o);
endmodule
`default_nettype wire

// *** bench/mac_mgmt_model.sv ***
// Purpose: management master driving the register port
// Assumes: called right after a rising edge
// Notes: strobes held until the next call, so calls may run back to back
`timescale 1ns/10ps
`default_nettype none
module mac_mgmt_model #(
  parameter bit long_cable = 1'b0
) (
  input wire logic clk_i,
  output logic [4:0] addr_o = 5'h00,
  output logic [15:0] wdata_o = 16'h0000,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  // op is {write, read}; 2'b00 idles the port
  task automatic access(input logic [1:0] op, input logic [4:0] a, input logic [15:0] d);
    addr_o <= a;
    wdata_o <= (d & 16'hFFEF) | {8'h00, long_cable, 7'h00};
    wr_o <= op[1];
    rd_o <= op[0];
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** bench/phy_special_control_bench.sv ***
// Purpose: self checking bench for the special control bits
// Assumes: ordinary and alternate variants, reference clock input held high
// Notes: control outputs are compared beside every read result
`timescale 1ns/10ps
`default_nettype none
module phy_special_control_bench;
  localparam logic [4:0] ctl = phy_ctl_pkg::ctl_offset;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic soft_rst_i = 1'b0;
  logic rd_q = 1'b0;
  logic [4:0] addr;
  logic [15:0] wdata, rdata;
  logic wr, rd, ck, st, pw, mdi, mdix, ax, lt;
  logic [5:0] sh;
  logic ck_alt, ax_alt;
  logic [24:0] exp_q[$];
  int err_count = 0;
  int checked = 0;
  initial forever #4 clk_i = ~clk_i;
  mac_mgmt_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  phy_special_control DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ref_clk_i(1'b1),
    .gigabit_ref_clock_out_o(ck), .collision_self_test_o(st), .mac_always_powered_o(pw),
    .force_mdi_o(mdi), .force_mdix_o(mdix), .auto_crossover_o(ax), .low_threshold_o(lt));
  phy_special_control #(.alt_variant(1'b1)) DUT_alt (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .soft_rst_i(soft_rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(),
    .ref_clk_i(1'b1), .gigabit_ref_clock_out_o(ck_alt), .collision_self_test_o(),
    .mac_always_powered_o(), .force_mdi_o(), .force_mdix_o(), .auto_crossover_o(ax_alt),
    .low_threshold_o());
  // sh holds bits 7:2 as the bench expects them
  function automatic logic [24:0] exp_of(input logic [5:0] s, input logic [4:0] a);
    return {8'h00, (a == ctl) ? s : 6'h00, 2'h0, ~s[2], s[0], s[1], s[4:3] == 2'h0,
      s[4:3] == 2'h1, s[4:3] == 2'h3, s[5], ~s[4], s[3]};
  endfunction
  task automatic compare(input logic [24:0] e, input logic [24:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  always @(posedge clk_i) begin
    rd_q <= rd && !sys_rst_i;
    if (rd_q) compare(exp_q.pop_front(), {rdata, ck, st, pw, mdi, mdix, ax, lt, ck_alt, ax_alt});
  end
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    host.access(2'h2, a, d);
    if (a == ctl) sh = {d[7:5], 1'b0, d[3:2]};
  endtask
  task automatic rd_reg(input logic [4:0] a);
    exp_q.push_back(exp_of(sh, a));
    host.access(2'h1, a, 16'h0000);
  endtask
  task automatic close_out;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    sh = 6'h1A;
    void'($urandom(84812));
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_reg(ctl);
    for (int i = 0; i < 4; i++) begin
      wr_reg(ctl, 16'(i << 5) | 16'h0084);
      rd_reg(ctl);
    end
    repeat (12) begin
      wr_reg(ctl, 16'($urandom));
      rd_reg(ctl);
      wr_reg(5'($urandom), 16'($urandom));
      rd_reg(5'($urandom));
    end
    wr_reg(ctl, 16'h0084);
    // write beside a software reset is dropped whole
    soft_rst_i <= 1'b1;
    host.access(2'h2, ctl, 16'h0008);
    soft_rst_i <= 1'b0;
    sh = {sh[5], 4'hD, sh[0]};
    rd_reg(ctl);
    host.access(2'h0, 5'h00, 16'h0000);
    for (int n = 0; n < 10 && exp_q.size() > 0; n++) @(posedge clk_i);
    if (exp_q.size() != 0) err_count++;
    close_out();
  end
endmodule
`default_nettype wire
